//--- design/scs_pkg.sv
// Package for the system clock select control block
package scs_pkg;
    // Register map (byte offsets on the plain register port)
    localparam logic [7:0] CRYSTAL_OSC_CONTROL_ADDR = 8'h0a;
    localparam logic [7:0] CLOCK_MODE_ADDR = 8'h03;
    localparam logic [7:0] OSC_STATUS_ADDR = 8'h0b;
    localparam logic [7:0] TRIM_CONFIG_ADDR = 8'h0c;
    // Crystal control fields
    localparam int XTAL_EN_BIT = 7;
    localparam int XTAL_DRV_HI = 6;
    localparam int XTAL_DRV_LO = 5;
    localparam logic [7:0] XTAL_RESET = 8'h00;
    localparam logic [1:0] DRV_NONE = 2'h0;
    localparam logic [1:0] DRV_LOW = 2'h1;
    localparam logic [1:0] DRV_MID = 2'h2;
    localparam logic [1:0] DRV_HIGH = 2'h3;
    // Clock mode fields
    localparam int FAST_EN_BIT = 4;
    localparam int SLOW_EN_BIT = 2;
    localparam logic [7:0] MODE_RESET = 8'h14;
    localparam logic [7:0] MODE_FAST_DIV2 = 8'h34;
    localparam logic [7:0] MODE_FAST_DIV4 = 8'h14;
    localparam logic [7:0] MODE_FAST_DIV8 = 8'h3c;
    localparam logic [7:0] MODE_FAST_DIV16 = 8'h1c;
    localparam logic [7:0] MODE_FAST_DIV32 = 8'h7c;
    localparam logic [7:0] MODE_SLOW = 8'he4;
    localparam logic [7:0] MODE_SLOW_FAST_ON = 8'hf4;
    localparam logic [7:0] MODE_XTAL = 8'hb0;
    localparam logic [7:0] MODE_XTAL_FAST_OFF = 8'ha0;
    // Clock mode code with enable bits masked (bits 7:5 and 3)
    localparam logic [7:0] SEL_MASK = 8'he8;
    localparam int DIV_WIDTH = 6;
    // Trim directive options
    typedef enum logic [2:0] {
        SCS_TRIM_DIV2 = 3'h0,
        SCS_TRIM_DIV4 = 3'h1,
        SCS_TRIM_DIV8 = 3'h2,
        SCS_TRIM_DIV16 = 3'h3,
        SCS_TRIM_DIV32 = 3'h4,
        SCS_TRIM_SLOW = 3'h5,
        SCS_TRIM_OFF = 3'h6
    } scs_trim_e;
    // Clock source selection
    typedef enum logic [2:0] {
        SCS_SRC_FAST = 3'b001,
        SCS_SRC_SLOW = 3'b010,
        SCS_SRC_XTAL = 3'b100
    } scs_src_e;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } scs_bus_s;
    typedef struct packed {
        logic fast_en;
        logic slow_en;
        logic xtal_en;
        logic [1:0] xtal_drive;
        logic wdt_en;
        logic trimmed;
    } scs_osc_s;
endpackage

//--- design/scs_clock_select.sv
// System clock source select, dividers and oscillator control registers
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
// Notes on behaviour
// - Slow trim option leaves mode at E4
// - Trim off: mode 04 or E4 by strap, fast untrimmed, off
// - Trim off boots watchdog on, slow running
// - Crystal control at 0x0a, bit7 enables
// - Bits 6:5 pick crystal drive strength
// - Mode write switches clock immediately
// - Value 34 selects fast/2, slow on
// - Value 14 selects fast/4
// - Value F4 selects slow, fast kept on
// - Value B0 selects crystal, fast kept on
// - Sources only fast, slow or crystal
// - Three independent oscillator enables
// - Boot enables both RC oscillators first
// - Values 3C, 1C, 7C give /8, /16, /32
module scs_clock_select (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire scs_pkg::scs_bus_s i_bus,
    output logic [7:0] o_rdata,
    input wire logic i_fast_rc_osc,
    input wire logic i_slow_rc_osc,
    input wire logic i_crystal_osc,
    input wire logic i_boot_done,
    input wire logic [2:0] i_factory_trim_directive,
    input wire logic i_fast_boot,
    output logic o_core_clock,
    output scs_pkg::scs_osc_s o_osc
);
    import scs_pkg::*;

    // Untrimmed boot values: the slow strap keeps the slow RC running with the fast RC off;
    // the fast strap lands on a code that no trimmed option uses, read back as /64
    localparam logic [7:0] MODE_UNTRIM_SLOW = MODE_SLOW & ~(8'h01 << FAST_EN_BIT);
    localparam logic [7:0] MODE_UNTRIM_FAST = (MODE_XTAL_FAST_OFF & ~SEL_MASK) | 8'h04;
    localparam logic [2:0] DIV_EXP_LAST = 3'h6;
    // Fields of the crystal control register that hold state
    localparam logic [7:0] XTAL_FIELD_MASK = 8'he0;

    // Register state
    logic [7:0] mode_q, mode_d;
    logic [7:0] xtal_q, xtal_d;
    logic wdt_q, wdt_d;
    logic trimmed_q, trimmed_d;
    logic booted_q, booted_d;
    logic [7:0] rdata_q, rdata_d;
    logic [DIV_WIDTH-1:0] div_q, div_d;

    // Pin synchronisers for the boot straps
    logic [1:0] boot_sync_q, boot_sync_d;
    logic [2:0] trim_s1_q, trim_s1_d;
    logic [2:0] trim_s2_q, trim_s2_d;
    logic fast_s1_q, fast_s1_d;
    logic fast_s2_q, fast_s2_d;

    // Decoded strobes and the clock path
    logic boot_apply;
    logic wr_mode;
    logic wr_xtal;
    scs_src_e src;
    logic [2:0] div_exp;
    logic [DIV_WIDTH-1:0] tap_sel;
    logic fast_clk;

    // Address match, shared by the write and the read decode
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] reg_addr);
        return a == reg_addr;
    endfunction

    // Source decode from the mode value; shared by mux and status read
    function automatic scs_src_e mode_source(input logic [7:0] m);
        if ((m & SEL_MASK) == (MODE_SLOW & SEL_MASK)) begin
            return SCS_SRC_SLOW;
        end else if ((m & SEL_MASK) == (MODE_XTAL & SEL_MASK)) begin
            return SCS_SRC_XTAL;
        end else begin
            return SCS_SRC_FAST;
        end
    endfunction

    // Fast RC divide ratio as a log2 exponent, taken from the mode value
    function automatic logic [2:0] mode_div(input logic [7:0] m);
        // The untrimmed fast code masks to the /4 pattern, so it is matched whole first
        if (m == MODE_UNTRIM_FAST) begin
            return DIV_EXP_LAST;
        end
        case (m & SEL_MASK)
            (MODE_FAST_DIV2 & SEL_MASK): return 3'h1;
            (MODE_FAST_DIV4 & SEL_MASK): return 3'h2;
            (MODE_FAST_DIV8 & SEL_MASK): return 3'h3;
            (MODE_FAST_DIV16 & SEL_MASK): return 3'h4;
            (MODE_FAST_DIV32 & SEL_MASK): return 3'h5;
            default: return DIV_EXP_LAST;
        endcase
    endfunction

    // Status word: two zero bits, booted, trimmed, watchdog enable, one-hot source
    function automatic logic [7:0] status_word(input logic [2:0] flags, input scs_src_e s);
        return {2'h0, flags, s};
    endfunction

    // Boot strap synchronisers: each stage reads only the one before it
    always_comb begin
        // The boot-done pin is a level, so two stages are enough for it
        boot_sync_d = {boot_sync_q[0], i_boot_done};
        trim_s1_d = i_factory_trim_directive;
        trim_s2_d = trim_s1_q;
        fast_s1_d = i_fast_boot;
        fast_s2_d = fast_s1_q;
    end

    // Registers only; the next values come from the block above
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            boot_sync_q <= 2'h0;
            trim_s1_q <= 3'h0;
            trim_s2_q <= 3'h0;
            fast_s1_q <= 1'b0;
            fast_s2_q <= 1'b0;
        end else begin
            boot_sync_q <= boot_sync_d;
            trim_s1_q <= trim_s1_d;
            trim_s2_q <= trim_s2_d;
            fast_s1_q <= fast_s1_d;
            fast_s2_q <= fast_s2_d;
        end
    end

    // Boot values land once, on the first edge that sees the synchronised boot-done;
    // writes are refused until then so software cannot race the trim
    always_comb begin
        boot_apply = !booted_q && boot_sync_q[1];
        // Mode and crystal writes are independent of each other
        wr_mode = booted_q && i_bus.wr && addr_is(i_bus.addr, CLOCK_MODE_ADDR);
        wr_xtal = booted_q && i_bus.wr && addr_is(i_bus.addr, CRYSTAL_OSC_CONTROL_ADDR);
    end

    // Register file and boot-time trim application
    always_comb begin
        mode_d = mode_q;
        xtal_d = xtal_q;
        wdt_d = wdt_q;
        trimmed_d = trimmed_q;
        booted_d = booted_q;

        if (boot_apply) begin
            // Every trimmed option leaves the watchdog off and the fast RC calibrated
            booted_d = 1'b1;
            trimmed_d = 1'b1;
            wdt_d = 1'b0;
            case (scs_trim_e'(trim_s2_q))
                SCS_TRIM_DIV2: begin
                    mode_d = MODE_FAST_DIV2;
                end
                SCS_TRIM_DIV4: begin
                    mode_d = MODE_FAST_DIV4;
                end
                SCS_TRIM_DIV8: begin
                    mode_d = MODE_FAST_DIV8;
                end
                SCS_TRIM_DIV16: begin
                    mode_d = MODE_FAST_DIV16;
                end
                SCS_TRIM_DIV32: begin
                    mode_d = MODE_FAST_DIV32;
                end
                SCS_TRIM_SLOW: begin
                    // Fast RC is left off; only the slow RC runs the core
                    mode_d = MODE_SLOW;
                end
                default: begin
                    // Trim off: the boot strap picks slow RC or fast RC /64, fast RC stays off
                    mode_d = fast_s2_q ? MODE_UNTRIM_FAST : MODE_UNTRIM_SLOW;
                    trimmed_d = 1'b0;
                    wdt_d = 1'b1;
                end
            endcase
        end else begin
            if (wr_mode) begin
                mode_d = i_bus.wdata;
            end
            if (wr_xtal) begin
                // Bits 4:0 are not implemented and read back as zero
                xtal_d = i_bus.wdata & XTAL_FIELD_MASK;
            end
        end
    end

    // Read data stands for one cycle after the strobe and is zero otherwise
    always_comb begin
        rdata_d = 8'h00;

        if (i_bus.rd) begin
            if (addr_is(i_bus.addr, CLOCK_MODE_ADDR)) begin
                rdata_d = mode_q;
            end else if (addr_is(i_bus.addr, CRYSTAL_OSC_CONTROL_ADDR)) begin
                rdata_d = xtal_q;
            end else if (addr_is(i_bus.addr, OSC_STATUS_ADDR)) begin
                rdata_d = status_word({booted_q, trimmed_q, wdt_q}, src);
            end else if (addr_is(i_bus.addr, TRIM_CONFIG_ADDR)) begin
                rdata_d = {4'h0, fast_s2_q, trim_s2_q};
            end else begin
                // Unmapped addresses read as zero
                rdata_d = 8'h00;
            end
        end
    end

    // Registers only; the next values come from the blocks above
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            mode_q <= MODE_RESET;
            xtal_q <= XTAL_RESET;
            wdt_q <= 1'b1;
            trimmed_q <= 1'b0;
            booted_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            mode_q <= mode_d;
            xtal_q <= xtal_d;
            wdt_q <= wdt_d;
            trimmed_q <= trimmed_d;
            booted_q <= booted_d;
            rdata_q <= rdata_d;
        end
    end

    // Free-running divider on the fast RC; a ripple of its own domain
    // The system reset clears it asynchronously, as the fast RC may be stopped then
    always_comb begin
        div_d = DIV_WIDTH'(div_q + 1'b1);
    end

    always_ff @(posedge i_fast_rc_osc or posedge i_rst) begin
        if (i_rst) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end

    // Tap g toggles at fast RC / 2^(g+1); one select line per ratio, one of them high
    always_comb begin
        div_exp = mode_div(mode_q);
    end

    for (genvar g = 0; g < DIV_WIDTH; g++) begin : g_tap
        assign tap_sel[g] = (div_exp == 3'(g + 1));
    end

    // A ratio change may leave one short period on the tap
    always_comb begin
        fast_clk = |(tap_sel & div_q);
    end

    // Combinational mux so a mode write takes effect at once; it is not glitch free,
    // which is why software keeps the old and the new oscillator running across a switch
    always_comb begin
        src = mode_source(mode_q);
        case (src)
            SCS_SRC_FAST: begin
                o_core_clock = fast_clk;
            end
            SCS_SRC_SLOW: begin
                o_core_clock = i_slow_rc_osc;
            end
            SCS_SRC_XTAL: begin
                // A stopped crystal gives a still clock, not a fault
                o_core_clock = i_crystal_osc;
            end
            default: begin
                // Not reachable: the decode is one-hot
                o_core_clock = i_slow_rc_osc;
            end
        endcase
    end

    // Read data straight from its register
    always_comb begin
        o_rdata = rdata_q;
    end

    // Oscillator controls straight from the registers
    always_comb begin
        o_osc.fast_en = mode_q[FAST_EN_BIT];
        o_osc.slow_en = mode_q[SLOW_EN_BIT];
        o_osc.xtal_en = xtal_q[XTAL_EN_BIT];
        o_osc.xtal_drive = xtal_q[XTAL_DRV_HI:XTAL_DRV_LO];
        o_osc.wdt_en = wdt_q;
        o_osc.trimmed = trimmed_q;
    end
endmodule

//--- tb/scs_osc_model.sv
// Model of the three oscillators feeding the block
`timescale 1ns/1ns
module scs_osc_model (
    input wire logic i_xtal_en,
    output logic o_fast,
    output logic o_slow,
    output logic o_xtal
);
    initial {o_fast, o_slow, o_xtal} = 3'h0;
    always #2 o_fast = ~o_fast;
    always #31 o_slow = ~o_slow;
    // A disabled crystal stands still at low
    always #7 o_xtal = i_xtal_en & ~o_xtal;
endmodule

//--- tb/scs_asserts.sv
// Port checker for the clock select block
`timescale 1ns/1ns
module scs_asserts (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire scs_pkg::scs_bus_s i_bus,
    input wire logic [7:0] o_rdata,
    input wire logic i_boot_done,
    input wire scs_pkg::scs_osc_s o_osc
);
    import scs_pkg::*;
    logic [2:0] up_q;
    logic wx;
    logic wm;
    logic wxa;
    assign wxa = i_bus.wr && i_bus.addr == CRYSTAL_OSC_CONTROL_ADDR;
    assign wx = i_bus.wr && i_bus.addr == CRYSTAL_OSC_CONTROL_ADDR && up_q > 3'h4;
    assign wm = i_bus.wr && i_bus.addr == CLOCK_MODE_ADDR && up_q > 3'h4;
    // Written values are judged well after the boot sync has settled; writes before boot-done must change nothing
    always_ff @(posedge i_clock) begin
        if (i_rst || !i_boot_done) up_q <= 3'h0;
        else if (up_q != 3'h7) up_q <= up_q + 3'h1;
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    chk_xtal_write: assert property (wx |=> {o_osc.xtal_en, o_osc.xtal_drive}
        == $past(i_bus.wdata[7:5])) else $error("crystal write lost");
    chk_mode_enables: assert property (wm |=> {o_osc.fast_en, o_osc.slow_en}
        == {$past(i_bus.wdata[4]), $past(i_bus.wdata[2])}) else $error("mode enables wrong");
    chk_xtal_hold: assert property (!wxa |=> $stable(o_osc.xtal_en))
        else $error("crystal enable moved");
    chk_read_idle: assert property (!$past(i_bus.rd) |-> o_rdata == 8'h00)
        else $error("read data outside slot");
    chk_xtal_read: assert property (i_bus.rd && i_bus.addr == CRYSTAL_OSC_CONTROL_ADDR |=>
        o_rdata == {o_osc.xtal_en, o_osc.xtal_drive, 5'h00}) else $error("crystal read wrong");
    chk_reset_vals: assert property ($fell(i_rst) |-> o_osc.fast_en && o_osc.slow_en
        && !o_osc.xtal_en && o_osc.xtal_drive == DRV_NONE) else $error("bad reset state");
    chk_trim_wdt: assert property (o_osc.trimmed |-> !o_osc.wdt_en)
        else $error("watchdog on after trim");
    chk_early_write: assert property (i_bus.wr && up_q == 3'h0 |=> $stable(o_osc))
        else $error("write taken before boot");
    cov_slow: cover property (wm && i_bus.wdata == MODE_SLOW_FAST_ON);
    cov_xtal: cover property (wm && i_bus.wdata == MODE_XTAL);
    cov_trim: cover property ($rose(o_osc.trimmed));
endmodule
bind scs_clock_select scs_asserts i_chk (.i_clock, .i_rst, .i_bus, .o_rdata, .i_boot_done, .o_osc);

//--- tb/tb_top.sv
// Self-checking bench for the clock select block
`timescale 1ns/1ns
module tb_top;
    import scs_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    scs_bus_s bus = '0;
    logic [7:0] rdata;
    logic fast, slow, xtal, core;
    logic boot = 1'b0;
    logic fb = 1'b0;
    logic [2:0] trim = 3'h1;
    scs_osc_s osc;
    int error_cnt = 0;
    int compares = 0;
    int cnt [4];
    logic [7:0] modes [5] = '{8'h34, 8'h14, 8'h3c, 8'h1c, 8'h7c};
    int divs [5] = '{2, 4, 8, 16, 32};
    always #5 i_clock = ~i_clock;
    always @(posedge fast) cnt[0]++;
    always @(posedge slow) cnt[1]++;
    always @(posedge xtal) cnt[2]++;
    always @(posedge core) cnt[3]++;
    scs_osc_model i_osc (.i_xtal_en(osc.xtal_en), .o_fast(fast), .o_slow(slow), .o_xtal(xtal));
    scs_clock_select i_dut (.i_clock, .i_rst, .i_bus(bus), .o_rdata(rdata), .i_fast_rc_osc(fast),
        .i_slow_rc_osc(slow), .i_crystal_osc(xtal), .i_boot_done(boot),
        .i_factory_trim_directive(trim), .i_fast_boot(fb), .o_core_clock(core), .o_osc(osc));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clock);
        bus <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clock);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clock);
        bus <= '0;
        #1 check(rdata, exp);
    endtask
    // Edge counts are polled per cycle, so one core edge of slack is allowed
    task automatic rate(input int s, input int div);
        int b;
        int c;
        int d;
        b = cnt[s];
        c = cnt[3];
        while (cnt[s] < b + 16 * div) @(posedge i_clock);
        b = (cnt[s] - b) / div;
        d = cnt[3] - c;
        if (d == b + 1 || d == b - 1) d = b;
        check(8'(d), 8'(b));
    endtask
    task automatic restart(input logic [2:0] t, input logic f);
        @(posedge i_clock);
        i_rst <= 1'b1;
        boot <= 1'b0;
        trim <= t;
        fb <= f;
        repeat (8) @(posedge i_clock);
        i_rst <= 1'b0;
    endtask
    task automatic up();
        @(posedge i_clock);
        boot <= 1'b1;
        repeat (6) @(posedge i_clock);
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        restart(3'h1, 1'b0);
        rd(CRYSTAL_OSC_CONTROL_ADDR, XTAL_RESET);
        rd(CLOCK_MODE_ADDR, MODE_RESET);
        wr(CRYSTAL_OSC_CONTROL_ADDR, 8'hff);
        up();
        rd(CRYSTAL_OSC_CONTROL_ADDR, XTAL_RESET);
        rd(CLOCK_MODE_ADDR, MODE_FAST_DIV4);
        $display("test boot done");
        foreach (modes[i]) begin
            wr(CLOCK_MODE_ADDR, modes[i]);
            rate(0, divs[i]);
        end
        wr(CLOCK_MODE_ADDR, MODE_SLOW_FAST_ON);
        rate(1, 1);
        rd(OSC_STATUS_ADDR, 8'h32);
        for (int d = 1; d < 4; d++) begin
            wr(CRYSTAL_OSC_CONTROL_ADDR, {1'b1, 2'(d), 5'h1f});
            rd(CRYSTAL_OSC_CONTROL_ADDR, {1'b1, 2'(d), 5'h00});
        end
        wr(CLOCK_MODE_ADDR, 8'hb4);
        rate(2, 1);
        wr(CLOCK_MODE_ADDR, MODE_XTAL);
        rate(2, 1);
        rd(OSC_STATUS_ADDR, 8'h34);
        wr(CLOCK_MODE_ADDR, MODE_FAST_DIV2);
        wr(CRYSTAL_OSC_CONTROL_ADDR, XTAL_RESET);
        rd(CRYSTAL_OSC_CONTROL_ADDR, XTAL_RESET);
        rd(8'h55, 8'h00);
        $display("test switching done");
        restart(3'h5, 1'b0);
        up();
        rd(CLOCK_MODE_ADDR, MODE_SLOW);
        rd(OSC_STATUS_ADDR, 8'h32);
        wr(CLOCK_MODE_ADDR, MODE_SLOW_FAST_ON);
        wr(CLOCK_MODE_ADDR, MODE_FAST_DIV2);
        rd(CLOCK_MODE_ADDR, MODE_FAST_DIV2);
        rate(0, 2);
        restart(3'h6, 1'b0);
        up();
        rd(OSC_STATUS_ADDR, 8'h2a);
        restart(3'h6, 1'b1);
        up();
        rd(OSC_STATUS_ADDR, 8'h29);
        rate(0, 64);
        $display("test trim options done");
        print_verdict();
    end
    initial begin
        #200000;
        error_cnt++;
        print_verdict();
    end
endmodule
